// *** rtl/fsfrc_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Check enable register at 0x1800, B0
// - Fault flag register at 0x1900, three flags
// - Flag B0 set after power-on recovery
// - Flag B1 set on redundant pair mismatch
// - Flag B2 set while in fail-safe
// - Flags stay set after cause goes
// - Reading fault register clears returned flags
// - Writing B0 at 0x1A00 resets device
// - Reset register self-clears on entering reset
// - Power-on release initialises registers, serial logic
// - Full defaults only on power cycle
// - Pair mismatch raises interrupt to controller
// - Reset pin becomes fail-safe pin when enabled
module fsfrc_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  fs_en_copy_a,
    input  wire logic [7:0]  fs_en_copy_b,
    input  wire logic [7:0]  fs_cfg_copy_a,
    input  wire logic [7:0]  fs_cfg_copy_b,
    input  wire logic        reset_pin_n,
    output logic             fault_irq,
    output logic             fail_safe_active,
    output logic             dev_reset_req,
    output logic             reg_reset_req,
    output logic             pin_reset_req
);
    import fsfrc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] base);
        hit = (a == base);
    endfunction : hit

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    logic pin_lvl;
    logic mism_en;
    logic mism_cfg;
    logic chk_en;

    fsfrc_sync u_pin_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_in    (reset_pin_n),
        .level_out (pin_lvl)
    );

    fsfrc_pair_cmp u_cmp_en (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .chk_en   (chk_en),
        .copy_a   (fs_en_copy_a),
        .copy_b   (fs_en_copy_b),
        .mismatch (mism_en)
    );

    fsfrc_pair_cmp u_cmp_cfg (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .chk_en   (chk_en),
        .copy_a   (fs_cfg_copy_a),
        .copy_b   (fs_cfg_copy_b),
        .mismatch (mism_cfg)
    );

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]       rchk_q,  rchk_d;
    logic [7:0]       fault_q, fault_d;
    logic [7:0]       swrst_q, swrst_d;
    logic [7:0]       rdata_q, rdata_d;
    logic             por_pend_q, por_pend_d;
    logic             fsafe_q, fsafe_d;
    fsfrc_rst_state_t st_q, st_d;
    logic [2:0]       cnt_q, cnt_d;
    logic             soft_clr;

    // Both fail-safe enable copies must agree before the pin is repurposed
    logic fs_enabled;
    assign fs_enabled = fs_en_copy_a[0] && fs_en_copy_b[0];

    // Device or register reset from the sequencer reloads the bank without POR
    assign soft_clr = (st_q == FSFRC_REG_RST) || (st_q == FSFRC_DEV_RST);
    assign chk_en   = rchk_q[FSFRC_RCHK_EN_BIT];

    // ------------------------------------------------------------------
    // Next-state: registers, flags, sequencer
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] set_v;
        set_v      = 8'h00;
        rchk_d     = rchk_q;
        fault_d    = fault_q;
        swrst_d    = swrst_q;
        rdata_d    = rdata_q;
        por_pend_d = 1'b0;
        fsafe_d    = fsafe_q;
        st_d       = st_q;
        cnt_d      = cnt_q;

        // Pin low while fail-safe armed means fail-safe entry
        if (fs_enabled) begin
            fsafe_d = fsafe_q || !pin_lvl;
        end else begin
            fsafe_d = 1'b0;
        end

        // Event sources for the sticky flags
        set_v[FSFRC_FLT_POR_BIT]   = por_pend_q;
        set_v[FSFRC_FLT_MISM_BIT]  = mism_en || mism_cfg;
        set_v[FSFRC_FLT_FSAFE_BIT] = fsafe_q;

        // Read returns the flags; clear only those returned
        if (reg_rd) begin
            if (hit(reg_addr, FSFRC_ADDR_RCHK)) begin
                rdata_d = rchk_q & FSFRC_RCHK_MASK;
            end else if (hit(reg_addr, FSFRC_ADDR_FAULT)) begin
                rdata_d = fault_q & FSFRC_FAULT_MASK;
                fault_d = 8'h00;
            end else if (hit(reg_addr, FSFRC_ADDR_SWRST)) begin
                rdata_d = swrst_q & FSFRC_SWRST_MASK;
            end else begin
                rdata_d = 8'h00;
            end
        end
        // Set wins over a same-cycle read clear; flags hold otherwise
        fault_d = (fault_d | set_v) & FSFRC_FAULT_MASK;

        // Writes; reserved bits dropped
        if (reg_wr && hit(reg_addr, FSFRC_ADDR_RCHK)) begin
            rchk_d = reg_wdata & FSFRC_RCHK_MASK;
        end
        if (reg_wr && hit(reg_addr, FSFRC_ADDR_SWRST)) begin
            swrst_d = reg_wdata & FSFRC_SWRST_MASK;
        end

        // Sequencer: decode request, hold reset output, self-clear
        case (st_q)
            FSFRC_IDLE: begin
                if (swrst_q[FSFRC_SW_DEV_BIT]) begin
                    st_d    = FSFRC_DEV_RST;
                    cnt_d   = 3'(FSFRC_RST_PULSE_CYC - 1);
                    swrst_d = FSFRC_SWRST_RST;
                end else if (swrst_q[FSFRC_SW_REG_BIT]) begin
                    st_d    = FSFRC_REG_RST;
                    cnt_d   = 3'(FSFRC_RST_PULSE_CYC - 1);
                    swrst_d = FSFRC_SWRST_RST;
                end
            end
            FSFRC_DEV_RST, FSFRC_REG_RST: begin
                if (cnt_q == 3'h0) begin
                    st_d = FSFRC_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                st_d = FSFRC_IDLE;
            end
        endcase

        // Soft reset restores the bank; the POR flag is not raised
        if (soft_clr) begin
            rchk_d  = FSFRC_RCHK_RST;
            fault_d = FSFRC_FAULT_RST;
            swrst_d = FSFRC_SWRST_RST;
            fsafe_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State registers; rst stands for power-on release
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rchk_q     <= FSFRC_RCHK_RST;
            fault_q    <= FSFRC_FAULT_RST;
            swrst_q    <= FSFRC_SWRST_RST;
            rdata_q    <= 8'h00;
            por_pend_q <= 1'b1;
            fsafe_q    <= 1'b0;
            st_q       <= FSFRC_IDLE;
            cnt_q      <= 3'h0;
        end else begin
            rchk_q     <= rchk_d;
            fault_q    <= fault_d;
            swrst_q    <= swrst_d;
            rdata_q    <= rdata_d;
            por_pend_q <= por_pend_d;
            fsafe_q    <= fsafe_d;
            st_q       <= st_d;
            cnt_q      <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Any pending flag requests attention; the pin driver is elsewhere
    assign fault_irq        = |fault_q;
    assign reg_rdata        = rdata_q;
    assign fail_safe_active = fsafe_q;
    assign dev_reset_req    = (st_q == FSFRC_DEV_RST);
    assign reg_reset_req    = (st_q == FSFRC_REG_RST);
    // Pin acts as reset only while fail-safe is neither armed nor held;
    // the latched state outlives the enables by one cycle
    assign pin_reset_req    = !fs_enabled && !fsafe_q && !pin_lvl;
endmodule : fsfrc_top

// *** rtl/fsfrc_pkg.sv ***
package fsfrc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] FSFRC_ADDR_RCHK  = 16'h1800;
    localparam logic [15:0] FSFRC_ADDR_FAULT = 16'h1900;
    localparam logic [15:0] FSFRC_ADDR_SWRST = 16'h1a00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FSFRC_RCHK_RST  = 8'h00;
    localparam logic [7:0] FSFRC_FAULT_RST = 8'h00;
    localparam logic [7:0] FSFRC_SWRST_RST = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FSFRC_RCHK_EN_BIT   = 0;
    localparam int FSFRC_FLT_POR_BIT   = 0;
    localparam int FSFRC_FLT_MISM_BIT  = 1;
    localparam int FSFRC_FLT_FSAFE_BIT = 2;
    localparam int FSFRC_SW_DEV_BIT    = 0;
    localparam int FSFRC_SW_REG_BIT    = 1;

    // Implemented-bit masks; everything else is reserved and reads zero
    localparam logic [7:0] FSFRC_RCHK_MASK  = 8'h01;
    localparam logic [7:0] FSFRC_FAULT_MASK = 8'h07;
    localparam logic [7:0] FSFRC_SWRST_MASK = 8'h03;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int FSFRC_CLK_NS         = 25;
    localparam int FSFRC_RST_PULSE_NS   = 100;
    localparam int FSFRC_RST_PULSE_CYC  =
        (FSFRC_RST_PULSE_NS + FSFRC_CLK_NS - 1) / FSFRC_CLK_NS;

    // Soft reset sequencer states
    typedef enum logic [1:0] {
        FSFRC_IDLE,
        FSFRC_DEV_RST,
        FSFRC_REG_RST
    } fsfrc_rst_state_t;

endpackage : fsfrc_pkg

// *** rtl/fsfrc_sync.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
// ----------------------------------------------------------------------
module fsfrc_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);
    import fsfrc_pkg::*;

    logic [2:0] stg_q;
    logic [2:0] stg_d;
    logic       lvl_q;
    logic       lvl_d;

    // Shift in; first stage is only read by the second
    always_comb begin
        stg_d = {stg_q[1:0], pin_in};
        lvl_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
    end

    // Reset idles the pin high (inactive low-level pin)
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stg_q <= 3'h7;
            lvl_q <= 1'b1;
        end else begin
            stg_q <= stg_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule : fsfrc_sync

// *** rtl/fsfrc_pair_cmp.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Compares redundant register copies, gated by the check enable
// ----------------------------------------------------------------------
module fsfrc_pair_cmp (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        chk_en,
    input  wire logic [7:0]  copy_a,
    input  wire logic [7:0]  copy_b,
    output logic             mismatch
);
    import fsfrc_pkg::*;

    logic mism_q;
    logic mism_d;

    // Registered to keep the long compare path out of the flag logic
    always_comb begin
        mism_d = chk_en && (copy_a != copy_b);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mism_q <= 1'b0;
        end else begin
            mism_q <= mism_d;
        end
    end

    assign mismatch = mism_q;
endmodule : fsfrc_pair_cmp

// *** tb/fsfrc_props.sv ***
`timescale 1ns/1ps
// ------------------------------
// Port checks of the fault bank
// ------------------------------
module fsfrc_props
    import fsfrc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reset_pin_n,
    input wire logic        fault_irq,
    input wire logic        fail_safe_active,
    input wire logic        dev_reset_req,
    input wire logic        reg_reset_req,
    input wire logic        pin_reset_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // A write during a running soft reset is overwritten, so skip it
    logic quiet;
    logic hit;
    assign quiet = !dev_reset_req && !reg_reset_req;
    assign hit = reg_addr inside {FSFRC_ADDR_RCHK, FSFRC_ADDR_FAULT,
                                  FSFRC_ADDR_SWRST};
    a_unmapped_zero: assert property (
        reg_rd && !hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rchk_reserved: assert property (
        reg_rd && reg_addr == FSFRC_ADDR_RCHK |=> reg_rdata[7:1] == 7'h00)
        else $error("check enable reserved bits set");
    a_flag_reserved: assert property (
        reg_rd && reg_addr == FSFRC_ADDR_FAULT |=> reg_rdata[7:3] == 5'h00)
        else $error("fault reserved bits set");
    a_dev_pulse: assert property (
        $rose(dev_reset_req) |-> dev_reset_req[*4] ##1 !dev_reset_req)
        else $error("device reset pulse length wrong");
    a_dev_start: assert property (
        reg_wr && reg_addr == FSFRC_ADDR_SWRST && reg_wdata[0] && quiet
        |-> ##2 dev_reset_req && !reg_reset_req)
        else $error("device reset not started");
    a_reg_start: assert property (
        reg_wr && reg_addr == FSFRC_ADDR_SWRST && quiet
        && reg_wdata[1:0] == 2'b10 |-> ##2 reg_reset_req && !dev_reset_req)
        else $error("register reset not started");
    a_pin_idle: assert property (
        reset_pin_n[*6] |-> !pin_reset_req)
        else $error("pin reset without low pin");
    a_fs_pin: assert property (
        fail_safe_active |-> !pin_reset_req)
        else $error("pin acts as reset in fail-safe");
    a_por_flag: assert property (
        $fell(rst) |=> fault_irq)
        else $error("no fault after power-on release");
    a_irq_matches: assert property (
        reg_rd && reg_addr == FSFRC_ADDR_FAULT && !fault_irq
        |=> reg_rdata == 8'h00)
        else $error("flags read back without interrupt");
    a_fs_irq: assert property (
        fail_safe_active |-> ##[0:2] fault_irq)
        else $error("fail-safe state not flagged");
endmodule : fsfrc_props
bind fsfrc_top fsfrc_props u_props (.*);

// *** tb/fsfrc_ctrl_model.sv ***
`timescale 1ns/1ps
// ----------------------------------
// Serial controller as seen by bank
// ----------------------------------
module fsfrc_ctrl_model
    import fsfrc_pkg::*;
(
    input wire logic        sys_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic     [15:0] reg_addr,
    output logic     [7:0]  reg_wdata,
    output logic     [7:0]  en_a,
    output logic     [7:0]  en_b,
    output logic     [7:0]  cfg_a,
    output logic     [7:0]  cfg_b
);
    // Bus quiet at time zero
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {en_a, en_b, cfg_a, cfg_b} = '0;
    end
    // One transfer every two cycles; released bus shows inverted values
    task xfer(input logic rd, input logic wr, input logic [15:0] a,
              input logic [7:0] d);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            #2;
            reg_rd = rd && i == 0;
            reg_wr = wr && i == 0;
            reg_addr = i == 0 ? a : ~a;
            reg_wdata = i == 0 ? d : ~d;
        end
    endtask : xfer
    // Redundant copies change together, just after an edge
    task pairs(input logic [7:0] e, input logic [7:0] ca,
               input logic [7:0] cb);
        @(posedge sys_clk);
        #2;
        en_a = e;
        en_b = e;
        cfg_a = ca;
        cfg_b = cb;
    endtask : pairs
    // Every copy is rewritten before the check is switched on
    task arm(input logic [7:0] ca, input logic [7:0] cb);
        pairs(8'h00, ca, cb);
        xfer(1'b0, 1'b1, FSFRC_ADDR_RCHK, 8'h01);
    endtask : arm
endmodule : fsfrc_ctrl_model

// *** tb/failsafe_fault_reset_control_test.sv ***
`timescale 1ns/1ps
// ------------------------------
// Self-checking bench
// ------------------------------
module failsafe_fault_reset_control_test
    import fsfrc_pkg::*;
;
    logic        sys_clk, rst, reset_pin_n, reg_wr, reg_rd, rd_p;
    logic        fault_irq, fail_safe_active, dev_reset_req;
    logic        reg_reset_req, pin_reset_req;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, en_a, en_b, cfg_a, cfg_b, r;
    logic [7:0]  exp_q[$];
    int          errors, n_checks, dc, rc;

    fsfrc_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .fs_en_copy_a(en_a), .fs_en_copy_b(en_b),
        .fs_cfg_copy_a(cfg_a), .fs_cfg_copy_b(cfg_b),
        .reset_pin_n(reset_pin_n), .fault_irq(fault_irq),
        .fail_safe_active(fail_safe_active), .dev_reset_req(dev_reset_req),
        .reg_reset_req(reg_reset_req), .pin_reset_req(pin_reset_req));
    fsfrc_ctrl_model ctl (.sys_clk(sys_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .en_a(en_a), .en_b(en_b), .cfg_a(cfg_a), .cfg_b(cfg_b));

    // 40 MHz clock
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Expected read data is queued by the driver before the read
    task rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        ctl.xfer(1'b1, 1'b0, a, 8'h00);
    endtask : rd
    task wr(input logic [15:0] a, input logic [7:0] d);
        ctl.xfer(1'b0, 1'b1, a, d);
    endtask : wr
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // Read data lands the cycle after the read edge
    always @(posedge sys_clk) rd_p <= reg_rd && !rst;
    always @(negedge sys_clk) begin
        if (rd_p) chk("rdata", exp_q.pop_front(), reg_rdata);
    end
    // A hang is cut short well past the expected run
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
    initial begin
        rst = 1;
        reset_pin_n = 1;
        r = 8'($urandom(81879));
        repeat (5) @(posedge sys_clk);
        #2 rst = 0;
        repeat (2) @(posedge sys_clk);
        rd(FSFRC_ADDR_RCHK, 8'h00);
        rd(FSFRC_ADDR_SWRST, 8'h00);
        rd(FSFRC_ADDR_FAULT, 8'h01);
        rd(FSFRC_ADDR_FAULT, 8'h00);
        rd({8'h1b, r}, 8'h00);
        wr(FSFRC_ADDR_RCHK, 8'hff);
        rd(FSFRC_ADDR_RCHK, 8'h01);
        wr(FSFRC_ADDR_FAULT, 8'hff);
        rd(FSFRC_ADDR_FAULT, 8'h00);
        wr(FSFRC_ADDR_RCHK, 8'h00);
        r = 8'($urandom);
        ctl.pairs(8'h00, r, ~r);
        repeat (4) @(posedge sys_clk);
        rd(FSFRC_ADDR_FAULT, 8'h00);
        ctl.arm(r, r);
        ctl.pairs(8'h00, r, ~r);
        repeat (4) @(posedge sys_clk);
        ctl.pairs(8'h00, r, r);
        repeat (4) @(posedge sys_clk);
        #2;
        chk("irq", 8'h01, 8'(fault_irq));
        rd(FSFRC_ADDR_FAULT, 8'h02);
        rd(FSFRC_ADDR_FAULT, 8'h00);
        chk("irq", 8'h00, 8'(fault_irq));
        ctl.pairs(8'h01, r, r);
        reset_pin_n = 0;
        repeat (8) @(posedge sys_clk);
        #2;
        chk("fs_act", 8'h01, 8'(fail_safe_active));
        chk("pin_rst", 8'h00, 8'(pin_reset_req));
        reset_pin_n = 1;
        rd(FSFRC_ADDR_FAULT, 8'h04);
        ctl.pairs(8'h00, r, r);
        repeat (6) @(posedge sys_clk);
        rd(FSFRC_ADDR_FAULT, 8'h04);
        rd(FSFRC_ADDR_FAULT, 8'h00);
        // Codes 1 and 3 reset the device, code 2 the registers only
        for (int i = 1; i < 4; i++) begin
            wr(FSFRC_ADDR_RCHK, 8'h01);
            wr(FSFRC_ADDR_SWRST, 8'(i));
            dc = 0;
            rc = 0;
            repeat (8) begin
                @(posedge sys_clk);
                #1;
                dc += int'(dev_reset_req);
                rc += int'(reg_reset_req);
            end
            chk("dev_req", i[0] ? 8'(FSFRC_RST_PULSE_CYC) : 8'h00,
                8'(dc));
            chk("reg_req", i == 2 ? 8'(FSFRC_RST_PULSE_CYC) : 8'h00,
                8'(rc));
            rd(FSFRC_ADDR_SWRST, 8'h00);
            rd(FSFRC_ADDR_RCHK, 8'h00);
            rd(FSFRC_ADDR_FAULT, 8'h00);
        end
        wr(FSFRC_ADDR_RCHK, 8'h01);
        @(posedge sys_clk);
        #2 rst = 1;
        repeat (2) @(posedge sys_clk);
        #2 rst = 0;
        repeat (2) @(posedge sys_clk);
        rd(FSFRC_ADDR_RCHK, 8'h00);
        rd(FSFRC_ADDR_FAULT, 8'h01);
        reset_pin_n = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk("pin_rst", 8'h01, 8'(pin_reset_req));
        report_and_stop();
    end
endmodule : failsafe_fault_reset_control_test
